// ===== design/gwd_params.svh
// Constants of the guarded watchdog timer: offsets, fields, resets, counts.
// Assumes an AXI4-Lite slave with 32-bit data and 18-bit byte addresses.
//
// Behaviour
// - Odd inhibit bits read one, never stored.
// - Counter write-enable bit gates counter writes.
// - Register write-enable gates run and flag writes.
// - Run set by inhibit zero plus run one.
// - Run clears on reset or permitted zero write.
// - Counter increments only while run is set.
// - Flag sets on overflow, clears by pin/write.
// - Counter readable; written value resumes counting upward.
// - Select bit picks system/8192 or sub/32.
// - Overflow past all ones, reset one cycle later.
// - Overflow reset lasts exactly 512 oscillator cycles.
// - Counter initialises to zero on reset.
// - Standby bit acts only while run clear.
// - Watch, subsleep, standby halt counter, retain control; subactive too unless subclock selected.
`ifndef GWD_PARAMS_SVH
`define GWD_PARAMS_SVH

`define GWD_ADDR_W 18
`define GWD_BYTE(i) ({i, 2'b00})
// Register indices; the byte address is four times the index.
`define GWD_IDX_CSR 16'hFFB2
`define GWD_IDX_CNT 16'hFFB3
`define GWD_IDX_STP 16'hFFFB
`define GWD_IDX_PMR 16'hFFCA
`define GWD_IDX_IST 16'hFFF0
`define GWD_IDX_IMK 16'hFFF1
// Control/status field positions.
`define GWD_B_CWI 7
`define GWD_B_CWE 6
`define GWD_B_RWI 5
`define GWD_B_RWE 4
`define GWD_B_RUI 3
`define GWD_B_RUN 2
`define GWD_B_FLI 1
`define GWD_B_FLG 0
`define GWD_B_STBY 2
`define GWD_B_CSEL 5
`define GWD_B_IOVF 0
// Read-back masks and reset values.
`define GWD_CSR_ONES 8'hAA
`define GWD_STP_ONES 8'hFB
`define GWD_CNT_RST 8'h00
`define GWD_CNT_MAX 8'hFF
// Timing counts; system and reset counts in base-clock cycles, subclock count in subclock edges.
`define GWD_SYS_DIV 8192
`define GWD_SUB_DIV 32
`define GWD_RST_CYC 512
`define GWD_SYS_LAST 13'h1FFF
`define GWD_SUB_LAST 5'h1F
`define GWD_RST_LOAD 10'h200
// AXI responses.
`define GWD_OKAY 2'h0
`define GWD_SLVERR 2'h2

`endif

// ===== design/gwd_pkg.sv
// Types of the guarded watchdog timer.
// Assumes gwd_params.svh for all numeric constants.
package gwd_pkg;

  // Chip power state as seen by the watchdog.
  typedef enum logic [2:0] {
    PWR_ACTIVE, PWR_SLEEP, PWR_WATCH, PWR_SUBACT, PWR_SUBSLP, PWR_STANDBY
  } gwd_pwr_t;

  // Overflow reset sequencer.
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PEND, SEQ_RESET} gwd_seq_t;

  // Stored control bits.
  typedef struct packed {
    logic counter_write_enable;
    logic register_write_enable;
    logic watchdog_run;
    logic overflow_reset_flag;
    logic watchdog_standby_ctrl;
    logic source_clock_select;
  } gwd_ctl_t;

  // Whole state of the block.
  typedef struct packed {
    gwd_ctl_t ctl;
    logic [7:0] counter;
    logic [12:0] sys_div;
    logic [4:0] sub_div;
    logic sub_prev;
    gwd_seq_t seq;
    logic [9:0] rst_cnt;
    logic rst_out;
    logic irq_stat;
    logic irq_mask;
    logic irq;
    logic aw_full;
    logic [17:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_strb;
    logic aw_rdy;
    logic w_rdy;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_rdy;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
  } gwd_state_t;

endpackage

// ===== design/gwd_top.sv
// Guarded watchdog timer with an AXI4-Lite register slave.
// It holds the control/status register, the 8-bit up-counter, the
// standby and source-select bits, an overflow interrupt and the
// sequencer that stretches an overflow into a chip reset pulse.
// Assumes SUB_CLK and POWER_STATE are synchronous to REF_CLK and that
// WDT_RESET_OUT is fed to the chip reset tree by the surrounding logic.
// That logic must not route WDT_RESET_OUT back to NRST, since the pin
// reset clears the flag that records the overflow.
`timescale 1ns/1ns
`include "gwd_params.svh"

module gwd_top (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic SUB_CLK,
  input wire gwd_pkg::gwd_pwr_t POWER_STATE,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [17:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [17:0] ARADDR,
  input wire logic [2:0] ARPROT,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic WDT_RESET_OUT,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // State.

  gwd_pkg::gwd_state_t st_reg;
  gwd_pkg::gwd_state_t st_next;

  // Prescaler enables and the selected counter input.
  logic sys_tick;
  logic sub_tick;
  logic cnt_tick;
  // Power gating of the counter and the control register.
  logic mod_stby;
  logic func_ok;
  // Bus strobes, write data and decoded read-back.
  logic do_write;
  logic do_read;
  logic [7:0] wd;
  logic [7:0] rd;
  logic rd_hit;
  logic wr_hit;
  // Counter write and count strobes of the current cycle.
  logic cnt_wr;
  logic cnt_inc;
  logic cnt_ovf;

  ////////////////////////////////////////////////////////////////////////
  // Read-back value of an addressed register.
  // Bit 8 of the result is the hit flag of a mapped address; the low
  // byte is what the register shows. Inhibit bits and unused bits read
  // as ones where the register defines them so.

  function automatic logic [8:0] read_reg(
    input gwd_pkg::gwd_state_t s,
    input logic [17:0] a
  );
    logic [8:0] r;
    r = 9'h000;
    case (a)
      `GWD_BYTE(`GWD_IDX_CSR): begin
        r[7:0] = `GWD_CSR_ONES;
        r[`GWD_B_CWE] = s.ctl.counter_write_enable;
        r[`GWD_B_RWE] = s.ctl.register_write_enable;
        r[`GWD_B_RUN] = s.ctl.watchdog_run;
        r[`GWD_B_FLG] = s.ctl.overflow_reset_flag;
        r[8] = 1'b1;
      end
      `GWD_BYTE(`GWD_IDX_CNT): begin
        r = {1'b1, s.counter};
      end
      `GWD_BYTE(`GWD_IDX_STP): begin
        r[7:0] = `GWD_STP_ONES;
        r[`GWD_B_STBY] = s.ctl.watchdog_standby_ctrl;
        r[8] = 1'b1;
      end
      `GWD_BYTE(`GWD_IDX_PMR): begin
        r[`GWD_B_CSEL] = s.ctl.source_clock_select;
        r[8] = 1'b1;
      end
      `GWD_BYTE(`GWD_IDX_IST): begin
        r[`GWD_B_IOVF] = s.irq_stat;
        r[8] = 1'b1;
      end
      `GWD_BYTE(`GWD_IDX_IMK): begin
        r[`GWD_B_IOVF] = s.irq_mask;
        r[8] = 1'b1;
      end
      default: begin
        r = 9'h000;
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Computes the whole next state from the current one and the inputs.
  always_comb begin
    st_next = st_reg;

    // Module standby only bites while the watchdog is stopped. A standby
    // request written while running is stored and takes hold as soon as
    // software clears the run bit.
    mod_stby = !st_reg.ctl.watchdog_standby_ctrl &&
               !st_reg.ctl.watchdog_run;

    // Counter and control logic work only in active and sleep, and in
    // subactive only with the subclock source. In every other state and
    // in module standby the counter halts and the control register keeps
    // its contents; writes to either are answered OKAY and dropped.
    case (POWER_STATE)
      gwd_pkg::PWR_ACTIVE: begin
        func_ok = !mod_stby;
      end
      gwd_pkg::PWR_SLEEP: begin
        func_ok = !mod_stby;
      end
      gwd_pkg::PWR_SUBACT: begin
        func_ok = !mod_stby && st_reg.ctl.source_clock_select;
      end
      default: begin
        func_ok = 1'b0;
      end
    endcase

    // Prescalers give one-cycle enables in the base clock domain, so the
    // counter never runs on a derived clock and every update of the state
    // happens on the REF_CLK edge. The system divider runs free, which
    // makes the first period after the run bit is set up to one tick
    // short; software sees this as the usual uncertainty of a watchdog.
    sys_tick = st_reg.sys_div == `GWD_SYS_LAST;
    sub_tick = SUB_CLK && !st_reg.sub_prev &&
               st_reg.sub_div == `GWD_SUB_LAST;
    st_next.sys_div = st_reg.sys_div + 13'h0001;
    // The subclock level is compared with its copy of the last cycle;
    // the copy resets low, the idle level, so no edge follows reset.
    st_next.sub_prev = SUB_CLK;
    if (SUB_CLK && !st_reg.sub_prev) begin
      st_next.sub_div = st_reg.sub_div + 5'h01;
    end
    cnt_tick = st_reg.ctl.source_clock_select ? sub_tick : sys_tick;

    // Write address and write data are taken in either order. Each slot
    // holds one item; only the low byte and its strobe are kept, since
    // every register is eight bits wide.
    if (AWVALID && st_reg.aw_rdy) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = AWADDR;
    end
    if (WVALID && st_reg.w_rdy) begin
      st_next.w_full = 1'b1;
      st_next.w_data = WDATA[7:0];
      st_next.w_strb = WSTRB[0];
    end

    // A write is performed once both halves are held.
    do_write = st_reg.aw_full && st_reg.w_full && !st_reg.b_valid;
    wd = st_reg.w_data;
    wr_hit = read_reg(st_reg, st_reg.aw_addr) > 9'h0FF;
    if (do_write) begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.b_valid = 1'b1;
      st_next.b_resp = wr_hit ? `GWD_OKAY : `GWD_SLVERR;
    end
    if (st_reg.b_valid && BREADY) begin
      st_next.b_valid = 1'b0;
    end
    // Both write slots stay closed until the response has been taken,
    // which keeps a second write from overtaking an unanswered one.
    st_next.aw_rdy = !st_next.aw_full && !st_next.b_valid;
    st_next.w_rdy = !st_next.w_full && !st_next.b_valid;

    // Reads answer one cycle after the address is taken. The read data is
    // captured at that edge and then stands unchanged until RREADY, even
    // if the counter moves on in the meantime.
    do_read = ARVALID && st_reg.ar_rdy;
    {rd_hit, rd} = read_reg(st_reg, ARADDR);
    if (st_reg.r_valid && RREADY) begin
      st_next.r_valid = 1'b0;
    end
    if (do_read) begin
      st_next.r_valid = 1'b1;
      st_next.r_data = {24'h000000, rd};
      st_next.r_resp = rd_hit ? `GWD_OKAY : `GWD_SLVERR;
    end
    st_next.ar_rdy = !st_next.r_valid;

    // Register writes; the control register holds still when halted.
    // Each protected bit of the control register moves only when its
    // inhibit bit is written zero in the same access, and the inhibit
    // bits themselves are never stored, so they always read back as one.
    if (do_write && st_reg.w_strb) begin
      case (st_reg.aw_addr)
        `GWD_BYTE(`GWD_IDX_CSR): begin
          if (func_ok) begin
            if (!wd[`GWD_B_CWI]) begin
              st_next.ctl.counter_write_enable = wd[`GWD_B_CWE];
            end
            if (!wd[`GWD_B_RWI]) begin
              st_next.ctl.register_write_enable = wd[`GWD_B_RWE];
            end
            if (st_reg.ctl.register_write_enable &&
                !wd[`GWD_B_RUI]) begin
              st_next.ctl.watchdog_run = wd[`GWD_B_RUN];
            end
            if (st_reg.ctl.register_write_enable &&
                !wd[`GWD_B_FLI] && !wd[`GWD_B_FLG]) begin
              st_next.ctl.overflow_reset_flag = 1'b0;
            end
          end
        end
        `GWD_BYTE(`GWD_IDX_CNT): begin
          if (func_ok && st_reg.ctl.counter_write_enable) begin
            st_next.counter = wd;
          end
        end
        `GWD_BYTE(`GWD_IDX_STP): begin
          st_next.ctl.watchdog_standby_ctrl = wd[`GWD_B_STBY];
        end
        `GWD_BYTE(`GWD_IDX_PMR): begin
          st_next.ctl.source_clock_select = wd[`GWD_B_CSEL];
        end
        `GWD_BYTE(`GWD_IDX_IST): begin
          if (wd[`GWD_B_IOVF]) begin
            st_next.irq_stat = 1'b0;
          end
        end
        `GWD_BYTE(`GWD_IDX_IMK): begin
          st_next.irq_mask = wd[`GWD_B_IOVF];
        end
        default: begin
          st_next.irq_mask = st_reg.irq_mask;
        end
      endcase
    end

    // A permitted counter write this cycle; it beats a tick in the same
    // cycle, so software reloading on time never races the overflow.
    cnt_wr = do_write && st_reg.w_strb && func_ok &&
             st_reg.ctl.counter_write_enable &&
             st_reg.aw_addr == `GWD_BYTE(`GWD_IDX_CNT);

    // One count step: running, powered, ticked and not in a reset pulse.
    cnt_inc = func_ok && st_reg.ctl.watchdog_run && cnt_tick &&
              st_reg.seq == gwd_pkg::SEQ_IDLE && !cnt_wr;

    // The step from all ones wraps to zero and starts the sequencer.
    cnt_ovf = cnt_inc && st_reg.counter == `GWD_CNT_MAX;

    // Counting continues upward from whatever value is held.
    if (cnt_inc) begin
      st_next.counter = st_reg.counter + 8'h01;
    end
    if (cnt_ovf) begin
      st_next.seq = gwd_pkg::SEQ_PEND;
    end

    // Overflow reset sequencer. PEND lasts one base-clock cycle; RESET
    // counts the pulse down from its full length and returns to IDLE as
    // the last cycle of the pulse is driven. The flag and the interrupt
    // status are set here, after the register writes above, so an
    // overflow wins over a clear that software issues in the same cycle.
    case (st_reg.seq)
      gwd_pkg::SEQ_IDLE: begin
        st_next.rst_cnt = 10'h000;
      end
      gwd_pkg::SEQ_PEND: begin
        // One base-clock cycle after the overflow the reset starts.
        st_next.seq = gwd_pkg::SEQ_RESET;
        st_next.rst_cnt = `GWD_RST_LOAD;
        st_next.ctl.overflow_reset_flag = 1'b1;
        st_next.irq_stat = 1'b1;
      end
      gwd_pkg::SEQ_RESET: begin
        st_next.rst_cnt = st_reg.rst_cnt - 10'h001;
        if (st_reg.rst_cnt == 10'h001) begin
          st_next.seq = gwd_pkg::SEQ_IDLE;
        end
      end
      default: begin
        st_next.seq = gwd_pkg::SEQ_IDLE;
      end
    endcase

    // The chip reset returns every watchdog bit but the flag to reset.
    // It is applied on every edge of the pulse but the one that ends it, so a write that lands while the
    // pulse is high cannot arm the watchdog again before the chip restarts.
    // The bus slots and the interrupt bits keep running, so the system
    // can read the cause once the processor comes back.
    if (st_next.seq == gwd_pkg::SEQ_RESET) begin
      st_next.ctl.counter_write_enable = 1'b0;
      st_next.ctl.register_write_enable = 1'b0;
      st_next.ctl.watchdog_run = 1'b0;
      st_next.ctl.watchdog_standby_ctrl = 1'b1;
      st_next.ctl.source_clock_select = 1'b0;
      st_next.counter = `GWD_CNT_RST;
      st_next.sys_div = 13'h0000;
      st_next.sub_div = 5'h00;
    end

    // Outputs are registered copies of their causes.
    st_next.rst_out = st_next.rst_cnt != 10'h000;
    st_next.irq = st_next.irq_stat && st_next.irq_mask;

    // The clock enable freezes everything, the bus handshake included;
    // a master must not expect an answer while CE is low. The subclock
    // copy is frozen too, so an edge seen during the freeze is counted
    // once CE returns only if the level is still high then.
    if (!CE) begin
      st_next = st_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  // Pin reset clears all state and sets the initial register values.
  // It is the only way to clear the flag other than a permitted write,
  // and it leaves the bus slots open so a request may follow at once.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st_reg <= '0;
      st_reg.ctl.watchdog_standby_ctrl <= 1'b1;
      st_reg.ctl.overflow_reset_flag <= 1'b0;
      st_reg.ctl.watchdog_run <= 1'b0;
      st_reg.counter <= `GWD_CNT_RST;
      st_reg.seq <= gwd_pkg::SEQ_IDLE;
      st_reg.aw_rdy <= 1'b1;
      st_reg.w_rdy <= 1'b1;
      st_reg.ar_rdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port drivers.

  // Every output is a field of the state register.
  // None of them passes through logic, so none of them can glitch.
  assign AWREADY = st_reg.aw_rdy;
  assign WREADY = st_reg.w_rdy;
  assign BVALID = st_reg.b_valid;
  assign BRESP = st_reg.b_resp;
  assign ARREADY = st_reg.ar_rdy;
  assign RVALID = st_reg.r_valid;
  assign RDATA = st_reg.r_data;
  assign RRESP = st_reg.r_resp;
  assign WDT_RESET_OUT = st_reg.rst_out;
  assign IRQ = st_reg.irq;

endmodule

// ===== tb/gwd_checker.sv
// Concurrent checks on the watchdog bus and chip reset output.
// Assumes it is bound to gwd_top and sees only its ports.
`timescale 1ns/1ns

module gwd_checker (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [1:0] BRESP,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  input wire logic WDT_RESET_OUT
);
  logic [9:0] hi_cnt;

  // Counts the cycles of the current chip reset pulse.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) hi_cnt <= 10'h000;
    else if (WDT_RESET_OUT) hi_cnt <= hi_cnt + 10'h001;
    else hi_cnt <= 10'h000;
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  ////////////////////////////////////////////////////////////////////////////
  // Both write halves taken together, and a response left waiting.
  sequence wr_both;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence b_wait;
    BVALID && !BREADY;
  endsequence

  rst_len_a: assert property (
    $fell(WDT_RESET_OUT) |-> hi_cnt == 10'h200)
    else $error("chip reset pulse ended at wrong length");
  rst_max_a: assert property (WDT_RESET_OUT |-> hi_cnt < 10'h200)
    else $error("chip reset pulse too long");
  wr_resp_a: assert property (wr_both |-> ##[1:2] BVALID)
    else $error("write response late");
  b_hold_a: assert property (b_wait |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  ar_block_a: assert property (RVALID |-> !ARREADY)
    else $error("read address taken while data pending");
  aw_block_a: assert property (BVALID |-> !AWREADY)
    else $error("write address taken while response pending");
  r_first_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  r_upper_a: assert property (RVALID |-> RDATA[31:8] == 24'h000000)
    else $error("upper read bits not zero");
endmodule

bind gwd_top gwd_checker u_chk (.REF_CLK, .NRST, .AWVALID, .AWREADY,
  .WVALID, .WREADY, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY,
  .RVALID, .RREADY, .RDATA, .WDT_RESET_OUT);

// ===== tb/gwd_top_test.sv
// Register-level bench of the guarded watchdog timer.
// Assumes gwd_top and its header; the bench drives SUB_CLK itself.
`timescale 1ns/1ns
`include "gwd_params.svh"

module gwd_top_test;
  logic REF_CLK, NRST, CE, SUB_CLK, AWVALID, AWREADY, WVALID, WREADY;
  logic BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic WDT_RESET_OUT, IRQ;
  logic [17:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [1:0] BRESP, RRESP, rs;
  logic [3:0] WSTRB;
  logic [2:0] AWPROT, ARPROT;
  gwd_pkg::gwd_pwr_t POWER_STATE;
  int bad_count, checks_done, cyc;
  logic [15:0] ix [6] = '{`GWD_IDX_CSR, `GWD_IDX_CNT, `GWD_IDX_STP,
    `GWD_IDX_PMR, `GWD_IDX_IST, `GWD_IDX_IMK};
  logic [7:0] rv [6] = '{8'hAA, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};

  gwd_top u_dut (.REF_CLK, .NRST, .CE, .SUB_CLK, .POWER_STATE, .AWVALID,
    .AWREADY, .AWADDR, .AWPROT, .WVALID, .WREADY, .WDATA, .WSTRB, .BVALID,
    .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .ARPROT, .RVALID,
    .RREADY, .RDATA, .RRESP, .WDT_RESET_OUT, .IRQ);

  // The 50 MHz base clock.
  initial begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One write; both halves offered together, each dropped when taken.
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    AWADDR <= `GWD_BYTE(i);
    WDATA <= {24'h000000, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    while (!(aw && w)) begin
      @(posedge REF_CLK);
      if (AWVALID && AWREADY) begin
        aw = 1'b1;
        AWVALID <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w = 1'b1;
        WVALID <= 1'b0;
      end
    end
    BREADY <= 1'b1;
    do @(posedge REF_CLK); while (BVALID !== 1'b1);
    rs = BRESP;
    BREADY <= 1'b0;
  endtask

  // One read, compared with the expected byte.
  task automatic rd(input string nm, input logic [15:0] i, logic [7:0] e);
    ARADDR <= `GWD_BYTE(i);
    ARVALID <= 1'b1;
    do @(posedge REF_CLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    RREADY <= 1'b1;
    do @(posedge REF_CLK); while (RVALID !== 1'b1);
    RREADY <= 1'b0;
    rs = RRESP;
    check(nm, RDATA, {24'h000000, e});
  endtask

  // Gives n subclock rising edges, four base cycles apart.
  task automatic sub(input int n);
    repeat (n) begin
      SUB_CLK <= 1'b1;
      repeat (2) @(posedge REF_CLK);
      SUB_CLK <= 1'b0;
      repeat (2) @(posedge REF_CLK);
    end
  endtask

  task automatic wait_rst(input logic v, input int lim);
    int n;
    n = 0;
    while (WDT_RESET_OUT !== v && n < lim) begin
      @(posedge REF_CLK);
      n++;
    end
    check("reset_out", {31'h0, WDT_RESET_OUT}, {31'h0, v});
  endtask

  task automatic irq_is(input logic e);
    @(posedge REF_CLK);
    check("irq", {31'h0, IRQ}, {31'h0, e});
  endtask

  // Cuts a hang short.
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {NRST, SUB_CLK, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 7'h00;
    {CE, WSTRB, AWPROT, ARPROT} = {1'b1, 4'hF, 6'h00};
    {AWADDR, ARADDR, WDATA} = '0;
    POWER_STATE = gwd_pkg::PWR_ACTIVE;
    {bad_count, checks_done, cyc} = '0;
    repeat (3) @(posedge REF_CLK);
    NRST <= 1'b1;
    @(posedge REF_CLK);
    for (int k = 0; k < 6; k++) rd("reset_value", ix[k], rv[k]);
    wr(`GWD_IDX_CNT, 8'h55);
    rd("cnt_locked", `GWD_IDX_CNT, 8'h00);
    wr(`GWD_IDX_CSR, 8'h04);
    rd("run_locked", `GWD_IDX_CSR, 8'hAA);
    wr(`GWD_IDX_CSR, 8'h50);
    rd("enables", `GWD_IDX_CSR, 8'hFA);
    wr(`GWD_IDX_CSR, 8'hFF);
    rd("inhibited", `GWD_IDX_CSR, 8'hFA);
    wr(`GWD_IDX_CNT, 8'h3C);
    rd("cnt_load", `GWD_IDX_CNT, 8'h3C);
    wr(16'h0010, 8'h00);
    check("wr_resp", {30'h0, rs}, {30'h0, `GWD_SLVERR});
    rd("unmapped", 16'h0010, 8'h00);
    check("rd_resp", {30'h0, rs}, {30'h0, `GWD_SLVERR});
    wr(`GWD_IDX_PMR, 8'h20);
    rd("select", `GWD_IDX_PMR, 8'h20);
    wr(`GWD_IDX_CSR, 8'h54);
    rd("run_set", `GWD_IDX_CSR, 8'hFE);
    wr(`GWD_IDX_STP, 8'h00);
    rd("standby", `GWD_IDX_STP, 8'hFB);
    wr(`GWD_IDX_CNT, 8'h00);
    sub(96);
    rd("count_up", `GWD_IDX_CNT, 8'h03);
    // A low clock enable freezes the counter and the subclock divider.
    CE <= 1'b0;
    sub(32);
    CE <= 1'b1;
    rd("ce_freeze", `GWD_IDX_CNT, 8'h03);
    POWER_STATE <= gwd_pkg::PWR_WATCH;
    sub(64);
    POWER_STATE <= gwd_pkg::PWR_ACTIVE;
    rd("watch_halt", `GWD_IDX_CNT, 8'h03);
    rd("watch_keep", `GWD_IDX_CSR, 8'hFE);
    wr(`GWD_IDX_CSR, 8'h50);
    rd("run_clear", `GWD_IDX_CSR, 8'hFA);
    sub(64);
    rd("stopped", `GWD_IDX_CNT, 8'h03);
    wr(`GWD_IDX_STP, 8'h04);
    wr(`GWD_IDX_CSR, 8'h54);
    wr(`GWD_IDX_CNT, 8'hFF);
    wr(`GWD_IDX_IMK, 8'h01);
    sub(32);
    wait_rst(1'b1, 20);
    wait_rst(1'b0, 600);
    rd("flag_set", `GWD_IDX_CSR, 8'hAB);
    rd("cnt_reset", `GWD_IDX_CNT, 8'h00);
    irq_is(1'b1);
    wr(`GWD_IDX_IMK, 8'h00);
    irq_is(1'b0);
    wr(`GWD_IDX_IMK, 8'h01);
    irq_is(1'b1);
    wr(`GWD_IDX_IST, 8'h01);
    irq_is(1'b0);
    wr(`GWD_IDX_CSR, 8'h10);
    wr(`GWD_IDX_CSR, 8'h18);
    rd("flag_clear", `GWD_IDX_CSR, 8'hBA);
    // Arms the watchdog, then pulls the pin reset in mid-run.
    wr(`GWD_IDX_CSR, 8'h54);
    NRST <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    NRST <= 1'b1;
    rd("pin_reset", `GWD_IDX_CSR, 8'hAA);
    // The free system divider restarts with the pin reset: one tick
    // 8192 cycles after release, the next 8192 cycles after that one.
    wr(`GWD_IDX_CSR, 8'h50);
    wr(`GWD_IDX_CSR, 8'h54);
    repeat (12000) @(posedge REF_CLK);
    rd("sys_tick", `GWD_IDX_CNT, 8'h01);
    tally_and_finish;
  end
endmodule
